// file: i2c_rate_core.sv
`timescale 1ns/1ns
`include "i2c_rate_cfg.svh"
module i2c_rate_core
  import i2c_rate_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  logic [7:0] own_slave_address;
  logic [7:0] bit_rate_divider;
  logic [7:0] next_own_slave_address;
  logic [7:0] next_bit_rate_divider;
  logic [7:0] next_rdata;
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  engine_state_t state, next_state;
  logic [CNT_W-1:0] tcnt, next_tcnt;
  logic scl_drv, next_scl_drv;
  logic sda_drv, next_sda_drv;
  logic tx_bit, next_tx_bit;
  logic rx_bit, next_rx_bit;
  logic frame, next_frame;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic first_byte, next_first_byte;
  logic ten_pending, next_ten_pending;
  logic match7, next_match7;
  logic match10, next_match10;
  logic [1:0] rate_multiplier_sel;
  logic [5:0] clock_rate_code;
  logic [1:0] mul_shift;
  rate_entry_t entry;
  logic [CNT_W-1:0] period, lo_cnt, hi_cnt, sda_cnt, start_cnt, stop_cnt;
  logic cmd_start, cmd_stop, cmd_bit;

  // Code 1F and all codes above it fall back to one default entry, slower than code 1E, so no code is left undefined.
  function automatic rate_entry_t rate_lookup(input logic [5:0] code);
    rate_entry_t e;
    e = '{8'hF0, 8'h21, 8'h76, 8'h79};
    unique case (code)
      6'h00: e = '{8'h14, 8'h07, 8'h06, 8'h0B};
      6'h01: e = '{8'h16, 8'h07, 8'h07, 8'h0C};
      6'h02: e = '{8'h18, 8'h08, 8'h08, 8'h0D};
      6'h03: e = '{8'h1A, 8'h08, 8'h09, 8'h0E};
      6'h04: e = '{8'h1C, 8'h09, 8'h0A, 8'h0F};
      6'h05: e = '{8'h1E, 8'h09, 8'h0B, 8'h10};
      6'h06: e = '{8'h22, 8'h0A, 8'h0D, 8'h12};
      6'h07: e = '{8'h28, 8'h0A, 8'h10, 8'h15};
      6'h08: e = '{8'h1C, 8'h07, 8'h0A, 8'h0F};
      6'h09: e = '{8'h20, 8'h07, 8'h0C, 8'h11};
      6'h0A: e = '{8'h24, 8'h09, 8'h0E, 8'h13};
      6'h0B: e = '{8'h28, 8'h09, 8'h10, 8'h15};
      6'h0C: e = '{8'h2C, 8'h0B, 8'h12, 8'h17};
      6'h0D: e = '{8'h30, 8'h0B, 8'h14, 8'h19};
      6'h0E: e = '{8'h38, 8'h0D, 8'h18, 8'h1D};
      6'h0F: e = '{8'h44, 8'h0D, 8'h1E, 8'h23};
      6'h10: e = '{8'h30, 8'h09, 8'h12, 8'h19};
      6'h11: e = '{8'h38, 8'h09, 8'h16, 8'h1D};
      6'h12: e = '{8'h40, 8'h0D, 8'h1A, 8'h21};
      6'h13: e = '{8'h48, 8'h0D, 8'h1E, 8'h25};
      6'h14: e = '{8'h50, 8'h11, 8'h22, 8'h29};
      6'h15: e = '{8'h58, 8'h11, 8'h26, 8'h2D};
      6'h16: e = '{8'h68, 8'h15, 8'h2E, 8'h35};
      6'h17: e = '{8'h80, 8'h15, 8'h3A, 8'h41};
      6'h18: e = '{8'h50, 8'h09, 8'h26, 8'h29};
      6'h19: e = '{8'h60, 8'h09, 8'h2E, 8'h31};
      6'h1A: e = '{8'h70, 8'h11, 8'h36, 8'h39};
      6'h1B: e = '{8'h80, 8'h11, 8'h3E, 8'h41};
      6'h1C: e = '{8'h90, 8'h19, 8'h46, 8'h49};
      6'h1D: e = '{8'hA0, 8'h19, 8'h4E, 8'h51};
      6'h1E: e = '{8'hC0, 8'h21, 8'h5E, 8'h61};
      default: e = '{8'hF0, 8'h21, 8'h76, 8'h79};
    endcase
    return e;
  endfunction

  assign rate_multiplier_sel = bit_rate_divider[`RATE_MULTIPLIER_SEL_MSB:`RATE_MULTIPLIER_SEL_LSB];
  assign clock_rate_code = bit_rate_divider[`CODE_MSB:0];
  // The reserved multiplier code runs at factor 1 rather than an undefined rate.
  assign mul_shift = (rate_multiplier_sel == 2'h3) ? 2'h0 : rate_multiplier_sel;
  assign entry = rate_lookup(clock_rate_code);
  assign period = CNT_W'({4'h0, entry.divider} << mul_shift);
  assign lo_cnt = period >> 1;
  assign hi_cnt = period - lo_cnt;
  assign sda_cnt = CNT_W'({4'h0, entry.sda_hold} << mul_shift);
  assign start_cnt = CNT_W'({4'h0, entry.start_hold} << mul_shift);
  assign stop_cnt = CNT_W'({4'h0, entry.stop_hold} << mul_shift);

  assign cmd_start = wr_in && addr_in == `OFS_BUS_COMMAND && wdata_in[`CMD_START];
  assign cmd_stop = wr_in && addr_in == `OFS_BUS_COMMAND && wdata_in[`CMD_STOP];
  assign cmd_bit = wr_in && addr_in == `OFS_BUS_COMMAND && wdata_in[`CMD_BIT];

  always_comb
  begin
    next_own_slave_address = own_slave_address;
    next_bit_rate_divider = bit_rate_divider;
    next_rdata = 8'h00;
    if (wr_in && addr_in == `OFS_OWN_SLAVE_ADDRESS)
    begin
      next_own_slave_address = {wdata_in[7:1], 1'b0};
    end
    if (wr_in && addr_in == `OFS_BIT_RATE_DIVIDER)
    begin
      next_bit_rate_divider = wdata_in;
    end
    if (rd_in)
    begin
      unique case (addr_in)
        `OFS_OWN_SLAVE_ADDRESS: next_rdata = {own_slave_address[7:1], 1'b0};
        `OFS_BIT_RATE_DIVIDER: next_rdata = bit_rate_divider;
        `OFS_BUS_STATUS: next_rdata = {3'h0, frame, match10, match7, rx_bit,
                                       state != st_idle && state != st_park};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Commands arriving while a timed phase runs are dropped; software polls busy first.
  always_comb
  begin
    next_state = state;
    next_tcnt = tcnt + CNT_W'(1);
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    next_tx_bit = tx_bit;
    next_rx_bit = rx_bit;
    unique case (state)
      st_idle:
      begin
        next_tcnt = '0;
        if (cmd_start && scl_sync && sda_sync)
        begin
          next_sda_drv = 1'b1;
          next_state = st_start;
        end
      end
      st_start:
      begin
        if (tcnt == start_cnt - CNT_W'(1))
        begin
          next_scl_drv = 1'b1;
          next_state = st_park;
        end
      end
      st_park:
      begin
        next_tcnt = '0;
        if (cmd_bit)
        begin
          next_tx_bit = wdata_in[`CMD_BIT_VALUE];
          next_state = st_bit_lo;
        end
        else if (cmd_stop)
        begin
          next_state = st_stop_lo;
        end
        else if (cmd_start)
        begin
          next_state = st_rs_lo;
        end
      end
      st_bit_lo, st_stop_lo, st_rs_lo:
      begin
        if (tcnt == sda_cnt - CNT_W'(1))
        begin
          next_sda_drv = (state == st_bit_lo) ? !tx_bit : (state == st_stop_lo);
        end
        if (tcnt == lo_cnt - CNT_W'(1))
        begin
          next_scl_drv = 1'b0;
          next_tcnt = '0;
          next_state = (state == st_bit_lo) ? st_bit_hi :
                       (state == st_stop_lo) ? st_stop_hi : st_rs_hi;
        end
      end
      default:
      begin
        // A party stretching the clock holds the count at zero until the line is high.
        if (!scl_sync)
        begin
          next_tcnt = '0;
        end
        else if (state == st_bit_hi)
        begin
          if (tcnt == '0)
          begin
            next_rx_bit = sda_sync;
          end
          if (tcnt == hi_cnt - CNT_W'(1))
          begin
            next_scl_drv = 1'b1;
            next_state = st_park;
          end
        end
        else if (state == st_stop_hi)
        begin
          if (tcnt == stop_cnt - CNT_W'(1))
          begin
            next_sda_drv = 1'b0;
            next_state = st_idle;
          end
        end
        else if (tcnt == hi_cnt - CNT_W'(1))
        begin
          next_sda_drv = 1'b1;
          next_tcnt = '0;
          next_state = st_start;
        end
      end
    endcase
  end

  // Watches every frame, our own included, and compares the addressing bytes.
  always_comb
  begin
    next_frame = frame;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_first_byte = first_byte;
    next_ten_pending = ten_pending;
    next_match7 = match7;
    next_match10 = match10;
    if (scl_sync && sda_prev && !sda_sync)
    begin
      next_frame = 1'b1;
      next_bit_cnt = 4'h0;
      next_first_byte = 1'b1;
      next_ten_pending = 1'b0;
      next_match7 = 1'b0;
      next_match10 = 1'b0;
    end
    else if (scl_sync && !sda_prev && sda_sync)
    begin
      next_frame = 1'b0;
    end
    else if (frame && !scl_prev && scl_sync)
    begin
      next_bit_cnt = (bit_cnt == `BITS_PER_SLOT - 4'h1) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt < 4'h8)
      begin
        next_shift = {shift[6:0], sda_sync};
      end
      if (bit_cnt == 4'h8)
      begin
        next_first_byte = 1'b0;
        next_ten_pending = 1'b0;
        if (first_byte)
        begin
          next_match7 = shift[7:1] == own_slave_address[7:1];
          next_ten_pending = shift[7:3] == `TEN_BIT_PREFIX;
        end
        else if (ten_pending)
        begin
          next_match10 = shift[6:0] == own_slave_address[7:1];
        end
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      own_slave_address <= `RST_OWN_SLAVE_ADDRESS;
      bit_rate_divider <= `RST_BIT_RATE_DIVIDER;
      rdata_out <= 8'h00;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      state <= st_idle;
      tcnt <= '0;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      tx_bit <= 1'b0;
      rx_bit <= 1'b0;
      frame <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      first_byte <= 1'b0;
      ten_pending <= 1'b0;
      match7 <= 1'b0;
      match10 <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end
    else
    begin
      own_slave_address <= next_own_slave_address;
      bit_rate_divider <= next_bit_rate_divider;
      rdata_out <= next_rdata;
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      state <= next_state;
      tcnt <= next_tcnt;
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
      tx_bit <= next_tx_bit;
      rx_bit <= next_rx_bit;
      frame <= next_frame;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      first_byte <= next_first_byte;
      ten_pending <= next_ten_pending;
      match7 <= next_match7;
      match10 <= next_match10;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= next_scl_drv;
      sda_oe_out <= next_sda_drv;
    end
  end

  a_addr_bit_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    rd_in && addr_in == `OFS_OWN_SLAVE_ADDRESS |=> rdata_out[0] == 1'b0)
    else $error("Address register bit 0 read back as one.");
  a_addr_write_kept: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    wr_in && addr_in == `OFS_OWN_SLAVE_ADDRESS |=>
      own_slave_address == {$past(wdata_in[7:1]), 1'b0})
    else $error("Own address field not stored from a write.");
  a_start_hold_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state == st_start && next_state == st_park |-> tcnt == start_cnt - CNT_W'(1) && sda_drv)
    else $error("Clock lowered at the wrong start hold count.");
  a_stop_hold_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state == st_stop_hi && next_state == st_idle |-> tcnt == stop_cnt - CNT_W'(1) && scl_sync)
    else $error("Data released at the wrong stop hold count.");
  a_data_hold_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state == st_bit_lo && next_sda_drv != sda_drv |-> tcnt == sda_cnt - CNT_W'(1))
    else $error("Data changed before the hold count elapsed.");
  a_bit_period_sum: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state == st_bit_hi && next_state == st_park |-> tcnt == hi_cnt - CNT_W'(1)
      && lo_cnt + hi_cnt == CNT_W'({4'h0, entry.divider} << mul_shift))
    else $error("High phase length does not match the bit period.");
  a_park_clock_low: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state == st_park ##1 state == st_park |-> scl_oe_out && !scl_out)
    else $error("Clock not held low while parked.");
  a_match_seven: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $rose(match7) |-> $past(shift[7:1]) == own_slave_address[7:1])
    else $error("Seven-bit match raised on a foreign address.");
  a_table_code_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    clock_rate_code == 6'h00 && rate_multiplier_sel == 2'h1 |->
      period == CNT_W'(40) && sda_cnt == CNT_W'(14) && stop_cnt == CNT_W'(22))
    else $error("Code zero scaled entry is wrong.");
endmodule

// file: i2c_rate_cfg.svh
`ifndef I2C_RATE_CFG_SVH
`define I2C_RATE_CFG_SVH
`define OFS_OWN_SLAVE_ADDRESS 3'h0
`define OFS_BIT_RATE_DIVIDER 3'h1
`define OFS_BUS_COMMAND 3'h2
`define OFS_BUS_STATUS 3'h3
`define RST_OWN_SLAVE_ADDRESS 8'h00
`define RST_BIT_RATE_DIVIDER 8'h00
`define RATE_MULTIPLIER_SEL_MSB 7
`define RATE_MULTIPLIER_SEL_LSB 6
`define CODE_MSB 5
`define CMD_START 0
`define CMD_STOP 1
`define CMD_BIT 2
`define CMD_BIT_VALUE 3
`define ST_BUSY 0
`define ST_RX_BIT 1
`define ST_MATCH7 2
`define ST_MATCH10 3
`define ST_FRAME 4
`define TEN_BIT_PREFIX 5'h1E
`define BITS_PER_SLOT 4'h9
`endif

// file: i2c_rate_pkg.sv
package i2c_rate_pkg;
  typedef enum logic [3:0] {
    st_idle,
    st_start,
    st_park,
    st_bit_lo,
    st_bit_hi,
    st_stop_lo,
    st_stop_hi,
    st_rs_lo,
    st_rs_hi
  } engine_state_t;
  typedef struct packed {
    logic [7:0] divider;
    logic [7:0] sda_hold;
    logic [7:0] start_hold;
    logic [7:0] stop_hold;
  } rate_entry_t;
endpackage

// file: i2c_bus_peer.sv
`timescale 1ns/1ns
// Far side of the two-wire bus: pull-ups plus another party that may hold either wire low.
module i2c_bus_peer
(
  input wire logic dev_scl_in,
  input wire logic dev_scl_oe_in,
  input wire logic dev_sda_in,
  input wire logic dev_sda_oe_in,
  input wire logic hold_scl_in,
  input wire logic hold_sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Wired-AND with pull-up: a released wire reads high, never the last driven value.
  // The driven level is taken from the device, so a wrong open-drain level breaks the link.
  assign scl_out = (dev_scl_oe_in ? dev_scl_in : 1'b1) & ~hold_scl_in;
  assign sda_out = (dev_sda_oe_in ? dev_sda_in : 1'b1) & ~hold_sda_in;
endmodule

// file: i2c_bit_rate_and_slave_address_test.sv
`timescale 1ns/1ns
`include "i2c_rate_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module i2c_bit_rate_and_slave_address_test;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic hold_scl = 1'b0;
  logic hold_sda = 1'b0;
  logic p_sda = 1'b0;
  logic p_scl = 1'b0;
  logic [7:0] v;
  wire [7:0] rdata_out;
  wire scl_oe_out;
  wire sda_oe_out;
  wire scl_w;
  wire sda_w;
  wire dev_scl;
  wire dev_sda;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_sda = 0;
  int t_scl = 0;
  int t_rel = 0;
  int t_cmd = 0;
  int d1;
  int h;
  // Columns: rate register value, divider, data hold, start hold, stop hold, multiplier shift.
  int tab [4][6] = '{'{8'h00, 20, 7, 6, 11, 0}, '{8'h5F, 240, 33, 118, 121, 1},
    '{8'h81, 22, 7, 7, 12, 2}, '{8'h14, 80, 17, 34, 41, 0}};
  always #2 clock_in = ~clock_in;
  i2c_bus_peer PEER (.dev_scl_in(dev_scl), .dev_scl_oe_in(scl_oe_out), .dev_sda_in(dev_sda),
    .dev_sda_oe_in(sda_oe_out), .hold_scl_in(hold_scl), .hold_sda_in(hold_sda),
    .scl_out(scl_w), .sda_out(sda_w));
  i2c_rate_core DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .scl_in(scl_w), .scl_out(dev_scl), .scl_oe_out(scl_oe_out), .sda_in(sda_w),
    .sda_out(dev_sda), .sda_oe_out(sda_oe_out));
  // Both edges of interest are stamped with the same sampling offset, so differences are exact.
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    p_sda <= sda_oe_out;
    p_scl <= scl_oe_out;
    if (sda_oe_out !== p_sda)
      t_sda <= cyc;
    if (scl_oe_out !== p_scl)
      t_scl <= cyc;
    if (p_scl === 1'b1 && scl_oe_out === 1'b0)
      t_rel <= cyc;
    if (wr_in === 1'b1 && addr_in === `OFS_BUS_COMMAND)
      t_cmd <= cyc;
    if (cyc == 30000)
    begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    d = rdata_out;
  endtask
  // Commands are dropped while busy, so every command waits here before the next one.
  task automatic idle();
    logic [7:0] s;
    repeat (2) @(posedge clock_in);
    for (int i = 0; i < 3000; i++)
    begin
      rd(`OFS_BUS_STATUS, s);
      if (s[`ST_BUSY] === 1'b0)
        break;
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(`OFS_BUS_COMMAND, c);
    idle();
  endtask
  task automatic sbit(input logic b);
    cmd((8'h01 << `CMD_BIT) | ({7'h00, b} << `CMD_BIT_VALUE));
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      sbit(b[i]);
  endtask
  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(`OFS_OWN_SLAVE_ADDRESS, v); `CHK(v, `RST_OWN_SLAVE_ADDRESS)
    rd(`OFS_BIT_RATE_DIVIDER, v); `CHK(v, `RST_BIT_RATE_DIVIDER)
    wr(`OFS_OWN_SLAVE_ADDRESS, 8'hA5); rd(`OFS_OWN_SLAVE_ADDRESS, v); `CHK(v, 8'hA4)
    wr(`OFS_BIT_RATE_DIVIDER, 8'hFF); rd(`OFS_BIT_RATE_DIVIDER, v); `CHK(v, 8'hFF)
    wr(`OFS_BIT_RATE_DIVIDER, 8'h40);
    rd(`OFS_BIT_RATE_DIVIDER, v);
    `CHK(v, 8'h40)
    wr(3'h5, 8'h3C); rd(3'h5, v); `CHK(v, 8'h00)
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_BIT_RATE_DIVIDER, tab[i][0]);
      cmd(8'h01 << `CMD_START);
      `CHK(t_scl - t_sda, tab[i][3] << tab[i][5])
      sbit(1'b1);
      `CHK(t_sda - t_cmd, (tab[i][2] << tab[i][5]) + 1)
      `CHK(t_rel - t_cmd, ((tab[i][1] << tab[i][5]) / 2) + 1)
      cmd(8'h01 << `CMD_STOP);
      h = t_sda - t_rel - (tab[i][4] << tab[i][5]);
      `CHK(h >= 1 && h <= 5, 1'b1)
    end
    $display("test timing done");
    wr(`OFS_BIT_RATE_DIVIDER, 8'h00);
    cmd(8'h01 << `CMD_START);
    send_byte(8'hA4);
    sbit(1'b1);
    rd(`OFS_BUS_STATUS, v); `CHK(v[`ST_MATCH7], 1'b1)
    hold_sda <= 1'b1;
    sbit(1'b1);
    hold_sda <= 1'b0;
    rd(`OFS_BUS_STATUS, v); `CHK(v[`ST_RX_BIT], 1'b0)
    sbit(1'b1);
    rd(`OFS_BUS_STATUS, v); `CHK(v[`ST_RX_BIT], 1'b1)
    cmd(8'h01 << `CMD_START);
    send_byte(8'hF0);
    sbit(1'b1);
    send_byte(8'h52);
    sbit(1'b1);
    rd(`OFS_BUS_STATUS, v); `CHK(v[`ST_MATCH10], 1'b1)
    `CHK(v[`ST_MATCH7], 1'b0)
    $display("test address done");
    sbit(1'b1);
    d1 = t_scl - t_cmd;
    hold_scl <= 1'b1;
    wr(`OFS_BUS_COMMAND, 8'h0C);
    repeat (60) @(posedge clock_in);
    hold_scl <= 1'b0;
    idle();
    h = t_scl - t_cmd - d1;
    `CHK(h > 40 && h < 60, 1'b1)
    cmd(8'h01 << `CMD_STOP);
    // The stop is seen through the input synchronisers, a few cycles after the engine idles.
    repeat (2) @(posedge clock_in);
    rd(`OFS_BUS_STATUS, v); `CHK(v[`ST_FRAME], 1'b0)
    $display("test stretch done");
    complete_run();
  end
endmodule
